// ### logic/cnn_node_ctl.sv
// top: avalon registers, switch sync, settings latch, traffic enables
`timescale 1ns/100ps
module cnn_node_ctl
  import cnn_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] cfg_sw,
  input wire logic nmt_valid,
  input wire logic [7:0] nmt_cmd,
  input wire logic [6:0] nmt_node,
  output logic [1:0] nmt_state,
  output logic [6:0] node_id,
  output logic [2:0] bit_rate,
  output logic [10:0] cob_tsdo,
  output logic [10:0] cob_rsdo,
  output logic [10:0] cob_tpdo,
  output logic [10:0] cob_emcy,
  output logic sdo_en,
  output logic pdo_en,
  output logic emcy_en,
  output logic guard_en,
  output logic lss_en
);

  // ========================================================================
  // switch synchroniser
  logic [7:0] sw_meta_ff;
  logic [7:0] sw_ff;

  // no reset: the chain fills with the switch levels while reset is held,
  // so the latch right after release already sees the real switches
  always_ff @(posedge clk) begin
    sw_meta_ff <= cfg_sw;
  end

  always_ff @(posedge clk) begin
    sw_ff <= sw_meta_ff;
  end

  // ========================================================================
  // stored settings and bus slave
  // stored values survive sys_rst, which stands for a power cycle; only
  // the power-on value is the factory setting
  logic [6:0] stored_id_ff = ID_RESET;
  logic [2:0] stored_rate_ff = RATE_RESET;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic wr_go;
  logic lss_ok;
  logic [6:0] sel_id;
  logic [2:0] sel_rate;
  logic [6:0] wr_id;
  logic [2:0] wr_lss_rate;
  logic [31:0] nxt_rdata;

  // one wait state: the edge with waitrequest low is the acceptance edge
  // one decode per write target, shared by the id and rate registers
  logic rd_take;
  logic wr_id_hit;
  logic wr_rate_hit;
  logic wr_lss_hit;
  logic lss_id_ok;

  assign wr_go = avs_write && !wait_ff;
  assign rd_take = avs_read && wait_ff;
  assign wr_id = avs_writedata[6:0];
  assign wr_lss_rate = avs_writedata[LSS_RATE_LSB+:3];
  assign wr_id_hit = wr_go && avs_address == ADDR_STORED_ID && wr_id != ID_MASTER;
  assign wr_rate_hit = wr_go && avs_address == ADDR_STORED_RATE;
  assign wr_lss_hit = wr_go && avs_address == ADDR_LSS && lss_ok;
  assign lss_id_ok = wr_lss_hit && wr_id != ID_MASTER;

  // waitrequest rises again right after the accept edge, so back to back
  // requests each see their own wait state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
    end
  end

  // id 0 is refused so the active id always stays a slave id
  always_ff @(posedge clk) begin
    if (wr_id_hit) begin
      stored_id_ff <= wr_id;
    end else if (lss_id_ok) begin
      stored_id_ff <= wr_id;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_rate_hit) begin
      stored_rate_ff <= avs_writedata[2:0];
    end else if (wr_lss_hit) begin
      stored_rate_ff <= wr_lss_rate;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (avs_address)
      ADDR_STORED_ID: nxt_rdata[6:0] = stored_id_ff;
      ADDR_STORED_RATE: nxt_rdata[2:0] = stored_rate_ff;
      ADDR_LSS: nxt_rdata[0] = lss_ok;
      ADDR_STATUS: begin
        nxt_rdata[STAT_STATE_LSB+:2] = nmt_state;
        nxt_rdata[STAT_ID_LSB+:7] = node_id;
        nxt_rdata[STAT_RATE_LSB+:3] = bit_rate;
        nxt_rdata[STAT_SW_LSB+:8] = sw_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // ========================================================================
  // selection and nmt state machine
  cnn_nmt_if nmt ();

  cnn_cfg_sel u_sel (
    .sw(sw_ff),
    .stored_id(stored_id_ff),
    .stored_rate(stored_rate_ff),
    .sel_id(sel_id),
    .sel_rate(sel_rate),
    .lss_ok(lss_ok)
  );

  // broadcast or addressed to this node
  assign nmt.cmd_valid = nmt_valid && (nmt_node == ID_MASTER || nmt_node == node_id);
  assign nmt.cmd = nmt_cmd;

  cnn_nmt_fsm u_fsm (
    .clk(clk),
    .sys_rst(sys_rst),
    .nmt(nmt.fsm)
  );

  // ========================================================================
  // active settings
  logic [6:0] id_ff;
  logic [2:0] rate_ff;
  logic rate_taken_ff;

  // the synchroniser is already filled at reset release; the latch pulse
  // holds the latch off for the first edge, so it is taken early in init
  logic id_taken_ff;

  // settings may be taken once the state machine sits in init and the
  // relatch pulse has passed
  logic init_open;
  assign init_open = nmt.state == CNN_INIT && !nmt.latch;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_taken_ff <= 1'b0;
    end else if (nmt.latch) begin
      id_taken_ff <= 1'b0;
    end else if (nmt.state == CNN_INIT && !id_taken_ff) begin
      id_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_ff <= ID_RESET;
    end else if (init_open && !id_taken_ff) begin
      id_ff <= sel_id;
    end
  end

  // rate is only taken once per power-up, device reset keeps it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_taken_ff <= 1'b0;
    end else if (init_open) begin
      rate_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_ff <= RATE_RESET;
    end else if (init_open && !rate_taken_ff) begin
      rate_ff <= sel_rate;
    end
  end

  // ========================================================================
  // registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmt_state <= 2'h0;
    end else begin
      nmt_state <= nmt.state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      node_id <= ID_RESET;
    end else begin
      node_id <= id_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_rate <= RATE_RESET;
    end else begin
      bit_rate <= rate_ff;
    end
  end

  // channel ids follow id_ff, so they change in the same edge as node_id
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cob_tsdo <= 11'h000;
    end else begin
      cob_tsdo <= cnn_cob(COB_TSDO, id_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cob_rsdo <= 11'h000;
    end else begin
      cob_rsdo <= cnn_cob(COB_RSDO, id_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cob_tpdo <= 11'h000;
    end else begin
      cob_tpdo <= cnn_cob(COB_TPDO, id_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cob_emcy <= 11'h000;
    end else begin
      cob_emcy <= cnn_cob(COB_EMCY, id_ff);
    end
  end

  // ========================================================================
  // traffic permissions per nmt state
  logic nxt_sdo_en;
  logic nxt_pdo_en;
  logic nxt_emcy_en;
  logic nxt_guard_en;

  always_comb begin
    nxt_sdo_en = 1'b0;
    nxt_pdo_en = 1'b0;
    nxt_emcy_en = 1'b0;
    nxt_guard_en = 1'b0;
    unique case (nmt.state)
      CNN_INIT: nxt_guard_en = 1'b0;
      CNN_PREOP: begin
        nxt_sdo_en = 1'b1;
        nxt_guard_en = 1'b1;
      end
      CNN_OPER: begin
        nxt_sdo_en = 1'b1;
        nxt_pdo_en = 1'b1;
        nxt_emcy_en = 1'b1;
        nxt_guard_en = 1'b1;
      end
      CNN_STOP: nxt_guard_en = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdo_en <= 1'b0;
    end else begin
      sdo_en <= nxt_sdo_en;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pdo_en <= 1'b0;
    end else begin
      pdo_en <= nxt_pdo_en;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      emcy_en <= 1'b0;
    end else begin
      emcy_en <= nxt_emcy_en;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      guard_en <= 1'b0;
    end else begin
      guard_en <= nxt_guard_en;
    end
  end

  // lss_en follows the synchronised switches, not the nmt state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lss_en <= 1'b0;
    end else begin
      lss_en <= lss_ok;
    end
  end

endmodule : cnn_node_ctl

// ### logic/cnn_pkg.sv
// constants, types and helpers for the node configuration and nmt block
// ==========================================================================
package cnn_pkg;

  // ========================================================================
  // register map, byte addresses
  localparam logic [3:0] ADDR_STORED_ID = 4'h0;
  localparam logic [3:0] ADDR_STORED_RATE = 4'h4;
  localparam logic [3:0] ADDR_LSS = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ID_LSB = 8;
  localparam int STAT_RATE_LSB = 16;
  localparam int STAT_SW_LSB = 24;
  localparam int LSS_RATE_LSB = 8;

  // ========================================================================
  // node id and bit rate
  localparam logic [6:0] ID_RESET = 7'h06;
  localparam logic [6:0] ID_MASTER = 7'h00;
  localparam logic [2:0] RATE_10K = 3'h0;
  localparam logic [2:0] RATE_20K = 3'h1;
  localparam logic [2:0] RATE_50K = 3'h2;
  localparam logic [2:0] RATE_125K = 3'h3;
  localparam logic [2:0] RATE_250K = 3'h4;
  localparam logic [2:0] RATE_500K = 3'h5;
  localparam logic [2:0] RATE_800K = 3'h6;
  localparam logic [2:0] RATE_1000K = 3'h7;
  localparam logic [2:0] RATE_RESET = RATE_125K;

  // ========================================================================
  // nmt commands and identifier bases
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RST_NODE = 8'h81;
  localparam logic [7:0] NMT_RST_COMM = 8'h82;
  localparam logic [10:0] COB_EMCY = 11'h080;
  localparam logic [10:0] COB_TPDO = 11'h180;
  localparam logic [10:0] COB_TSDO = 11'h580;
  localparam logic [10:0] COB_RSDO = 11'h600;

  // cycles spent initialising before pre-operational
  localparam int INIT_CYCLES = 4;

  typedef enum logic [1:0] {CNN_INIT, CNN_PREOP, CNN_OPER, CNN_STOP} cnn_state_e;

  // channel identifier is base plus node id
  function automatic logic [10:0] cnn_cob(input logic [10:0] base, input logic [6:0] id);
    cnn_cob = base + {4'h0, id};
  endfunction : cnn_cob

endpackage : cnn_pkg

// ### logic/cnn_nmt_if.sv
// nmt command and state carrier between controller and state machine
`timescale 1ns/100ps
interface cnn_nmt_if;
  import cnn_pkg::*;
  logic cmd_valid;
  logic [7:0] cmd;
  cnn_state_e state;
  logic latch;
  modport fsm (input cmd_valid, input cmd, output state, output latch);
  modport ctl (output cmd_valid, output cmd, input state, input latch);
endinterface : cnn_nmt_if

// ### logic/cnn_nmt_fsm.sv
// nmt state machine of the node
`timescale 1ns/100ps
module cnn_nmt_fsm
  import cnn_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  cnn_nmt_if.fsm nmt
);

  // ========================================================================
  // state and init timer
  cnn_state_e state_ff;
  logic [7:0] init_cnt_ff;
  logic latch_ff;
  logic is_reset_cmd;

  assign is_reset_cmd = nmt.cmd_valid && (nmt.cmd == NMT_RST_NODE || nmt.cmd == NMT_RST_COMM);
  assign nmt.state = state_ff;
  assign nmt.latch = latch_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= CNN_INIT;
      init_cnt_ff <= 8'h00;
    end else if (is_reset_cmd) begin
      state_ff <= CNN_INIT;
      init_cnt_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        CNN_INIT: begin
          if (init_cnt_ff == 8'(INIT_CYCLES - 1)) begin
            state_ff <= CNN_PREOP;
          end else begin
            init_cnt_ff <= init_cnt_ff + 8'h01;
          end
        end
        CNN_PREOP, CNN_OPER, CNN_STOP: begin
          if (nmt.cmd_valid && nmt.cmd == NMT_START) begin
            state_ff <= CNN_OPER;
          end else if (nmt.cmd_valid && nmt.cmd == NMT_STOP) begin
            state_ff <= CNN_STOP;
          end else if (nmt.cmd_valid && nmt.cmd == NMT_PREOP) begin
            state_ff <= CNN_PREOP;
          end
        end
      endcase
    end
  end

  // settings latch once per entry into init
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_ff <= 1'b1;
    end else begin
      latch_ff <= is_reset_cmd;
    end
  end

endmodule : cnn_nmt_fsm

// ### logic/cnn_cfg_sel.sv
// picks node id and bit rate from switches or stored values
`timescale 1ns/100ps
module cnn_cfg_sel
  import cnn_pkg::*;
(
  input wire logic [7:0] sw,
  input wire logic [6:0] stored_id,
  input wire logic [2:0] stored_rate,
  output logic [6:0] sel_id,
  output logic [2:0] sel_rate,
  output logic lss_ok
);

  // ========================================================================
  // selection
  always_comb begin
    if (sw[5:0] == 6'h00) begin
      sel_id = stored_id;
    end else begin
      sel_id = {1'b0, sw[5:0]};
    end
    unique case ({sw[7], sw[6]})
      2'b10: sel_rate = RATE_250K;
      2'b01: sel_rate = RATE_500K;
      2'b11: sel_rate = RATE_1000K;
      2'b00: sel_rate = stored_rate;
    endcase
    lss_ok = (sw == 8'h00);
  end

endmodule : cnn_cfg_sel

// ### bench/cnn_node_ctl_props.sv
// assertions on the ports of the node configuration and nmt block
`timescale 1ns/100ps
module cnn_node_ctl_props
  import cnn_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic nmt_valid,
  input wire logic [7:0] nmt_cmd,
  input wire logic [6:0] nmt_node,
  input wire logic [1:0] nmt_state,
  input wire logic [6:0] node_id,
  input wire logic [2:0] bit_rate,
  input wire logic [10:0] cob_tsdo,
  input wire logic sdo_en,
  input wire logic pdo_en,
  input wire logic emcy_en,
  input wire logic guard_en
);
  // ==========================================================================
  // helpers
  logic hit;
  assign hit = nmt_valid && (nmt_node == 7'h00 || nmt_node == node_id);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence reinit_s;
    nmt_state == 2'h0 ##[1:12] nmt_state == 2'h1;
  endsequence
  // ==========================================================================
  // properties
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
  boot_preop_a: assert property ($fell(sys_rst) |-> ##[1:12] nmt_state == 2'h1)
    else $error("no pre-operational after init");
  preop_en_a: assert property (nmt_state == 2'h1 |-> sdo_en && !pdo_en && !emcy_en)
    else $error("wrong traffic enables in pre-operational");
  oper_en_a: assert property (nmt_state == 2'h2 |-> sdo_en && pdo_en && emcy_en)
    else $error("wrong traffic enables in operational");
  stop_en_a: assert property (nmt_state == 2'h3 |-> guard_en && !sdo_en && !pdo_en && !emcy_en)
    else $error("wrong traffic enables in stopped");
  start_cmd_a: assert property (hit && nmt_cmd == NMT_START && nmt_state != 2'h0
    |-> ##2 nmt_state == 2'h2)
    else $error("start command not obeyed");
  cob_id_a: assert property (nmt_state != 2'h0 |-> cob_tsdo == COB_TSDO + {4'h0, node_id})
    else $error("channel id not based on node id");
  slave_id_a: assert property (nmt_state != 2'h0 |-> node_id != ID_MASTER)
    else $error("node id zero in use");
  rate_hold_a: assert property (nmt_state != 2'h0 |=> $stable(bit_rate))
    else $error("bit rate changed without power cycle");
  reset_cmd_a: assert property (hit && nmt_cmd == NMT_RST_NODE && nmt_state != 2'h0
    |-> ##2 reinit_s)
    else $error("device reset did not reinitialise");
endmodule : cnn_node_ctl_props
bind cnn_node_ctl cnn_node_ctl_props u_cnn_node_ctl_props (.*);

// ### bench/cnn_master_model.sv
// network master model that issues nmt commands
`timescale 1ns/100ps
module cnn_master_model (
  input wire logic clk,
  output logic nmt_valid,
  output logic [7:0] nmt_cmd,
  output logic [6:0] nmt_node
);
  initial begin
    nmt_valid = 1'b0;
    nmt_cmd = 8'hA5;
    nmt_node = 7'h5A;
  end
  // idle lines carry inverted junk so stale codes never pass as valid
  task automatic send(input logic [7:0] c, input logic [6:0] n);
    @(posedge clk);
    nmt_valid <= 1'b1;
    nmt_cmd <= c;
    nmt_node <= n;
    @(posedge clk);
    nmt_valid <= 1'b0;
    nmt_cmd <= ~c;
    nmt_node <= ~n;
  endtask : send
endmodule : cnn_master_model

// ### bench/tb_top.sv
// self-checking bench for the node configuration and nmt block
`timescale 1ns/100ps
module tb_top
  import cnn_pkg::*;
;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, nmt_valid;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [7:0] cfg_sw, nmt_cmd;
  logic [6:0] nmt_node, node_id;
  logic [1:0] nmt_state;
  logic [2:0] bit_rate;
  logic [10:0] cob_tsdo, cob_rsdo, cob_tpdo, cob_emcy;
  logic sdo_en, pdo_en, emcy_en, guard_en, lss_en;
  int fail_count, comparisons;
  logic [7:0] cmds [5] = '{NMT_START, NMT_STOP, NMT_START, NMT_PREOP, 8'h55};
  logic [6:0] nds [5] = '{7'h00, 7'h06, 7'h07, 7'h06, 7'h00};
  logic [1:0] sts [5] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
  logic [3:0] ens [5] = '{4'hF, 4'h1, 4'h1, 4'h9, 4'h9};
  logic [7:0] sws [2] = '{8'h7F, 8'hC1};
  logic [6:0] ids [2] = '{7'h3F, 7'h01};
  logic [2:0] rts [2] = '{RATE_500K, RATE_1000K};

  cnn_node_ctl u_cnn_node_ctl (.*);
  cnn_master_model u_cnn_master_model (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one bus cycle; idle edge after release avoids a double drive
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) fail_count++;
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic settle();
    int n;
    n = 0;
    tick(3);
    while (nmt_state !== 2'h1 && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) fail_count++;
  endtask : settle
  task automatic power(input logic [7:0] sw);
    cfg_sw <= sw;
    sys_rst <= 1'b1;
    tick(16);
    sys_rst <= 1'b0;
    settle();
  endtask : power
  task automatic node_reset(input logic [7:0] c);
    u_cnn_master_model.send(c, 7'h00);
    settle();
  endtask : node_reset
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // ==========================================================================
  // tests
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    cfg_sw = 8'h00;
    fail_count = 0;
    comparisons = 0;
    power(8'h00);
    chk("state", nmt_state, 2'h1);
    chk("id", node_id, 7'h06);
    chk("rate", bit_rate, RATE_125K);
    av(1'b0, ADDR_STORED_ID, 32'h0);
    chk("stored id", d, 32'h6);
    av(1'b0, ADDR_LSS, 32'h0);
    chk("lss open", d[0], 1'b1);
    chk("lss_en", lss_en, 1'b1);
    for (int i = 0; i < 5; i++) begin
      u_cnn_master_model.send(cmds[i], nds[i]);
      tick(3);
      chk("state", nmt_state, sts[i]);
      chk("enables", {sdo_en, pdo_en, emcy_en, guard_en}, ens[i]);
    end
    av(1'b1, ADDR_STORED_ID, 32'h25);
    av(1'b1, ADDR_STORED_ID, 32'h0);
    for (int r = 0; r < 8; r++) begin
      av(1'b1, ADDR_STORED_RATE, r);
      av(1'b0, ADDR_STORED_RATE, 32'h0);
      chk("stored rate", d, r);
    end
    av(1'b0, ADDR_STORED_ID, 32'h0);
    chk("stored id", d, 32'h25);
    node_reset(NMT_RST_NODE);
    chk("id", node_id, 7'h25);
    chk("cob", {cob_tsdo, cob_rsdo, cob_tpdo, cob_emcy}, {11'h5A5, 11'h625, 11'h1A5, 11'h0A5});
    chk("rate", bit_rate, RATE_125K);
    av(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    av(1'b0, ADDR_STATUS, 32'h0);
    chk("status", d, 32'h00032501);
    cfg_sw <= 8'h80;
    tick(4);
    av(1'b1, ADDR_LSS, 32'h0312);
    node_reset(NMT_RST_NODE);
    chk("id", node_id, 7'h25);
    chk("rate", bit_rate, RATE_125K);
    cfg_sw <= 8'h00;
    tick(4);
    av(1'b1, ADDR_LSS, 32'h0611);
    node_reset(NMT_RST_COMM);
    chk("id", node_id, 7'h11);
    power(8'h00);
    chk("id", node_id, 7'h11);
    chk("rate", bit_rate, RATE_800K);
    power(8'h81);
    chk("id", node_id, 7'h01);
    chk("rate", bit_rate, RATE_250K);
    for (int i = 0; i < 2; i++) begin
      power(sws[i]);
      chk("id", node_id, ids[i]);
      chk("rate", bit_rate, rts[i]);
      av(1'b0, ADDR_LSS, 32'h0);
      chk("lss shut", d[0], 1'b0);
      chk("lss_en", lss_en, 1'b0);
    end
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : tb_top
